// *** bench/ssw_host_model.sv ***
// Host processor and memory path model driving the kick and raw chip select
`timescale 1ns/1ps
module ssw_host_model #(
    parameter int unsigned KICK_GAP = 10
) (
    input  wire logic i_clk,
    input  wire logic i_arst_n,
    input  wire logic i_reset_n,
    input  wire logic i_kick_en,
    input  wire logic i_cs_req,
    output logic      o_kick,
    output logic      o_cs_raw_n
);
    int unsigned gap_q;
    // Processor held in reset does not kick
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            gap_q  <= 0;
            o_kick <= 1'b0;
        end else if (i_kick_en && i_reset_n) begin
            gap_q <= (gap_q == KICK_GAP - 1) ? 0 : gap_q + 1;
            if (gap_q == KICK_GAP - 1) begin
                o_kick <= ~o_kick;
            end
        end
    end
    assign o_cs_raw_n = ~i_cs_req;
endmodule : ssw_host_model

// *** bench/tb_top.sv ***
// Self-checking testbench for the supply supervisor
`timescale 1ns/1ps
module tb_top;
    localparam int STR = 20;
    localparam int WDT = 50;
    localparam int WDP = 5;
    localparam int CPT = 20;
    logic        i_clk = 1'b0;
    logic        i_arst_n = 1'b0;
    logic        ext = 1'b0, vbr = 1'b0, vbl = 1'b0, rsl = 1'b0, lsl = 1'b0, ovh = 1'b0;
    logic        tied = 1'b1, s5v = 1'b0, mr_n = 1'b1, kick_en = 1'b0, cs_req = 1'b0;
    logic [15:0] cap = 16'h0000;
    logic        kick, cs_raw_n;
    logic        rst_n, rst, ll_n, ov_n, wdf_n, wdp_n, cs_n, oe_n;
    int          num_errors = 0;
    int          check_count = 0;
    int          n;
    int          lim;
    always #25 i_clk = ~i_clk;
    ssw_supervisor #(.STRETCH_CYC(STR), .WDT_DEFAULT_CYC(WDT), .WDPULSE_CYC(WDP),
                     .CYC_PER_TENTH_MS(CPT)) u_dut (
        .i_clk(i_clk), .i_arst_n(i_arst_n), .i_ext_mode(ext), .i_vcc_below_reset(vbr),
        .i_vcc_below_lowline(vbl), .i_reset_sense_low(rsl), .i_lowline_sense_input_low(lsl),
        .i_overvoltage_sense_in_high(ovh), .i_timeout_select_input_tied(tied), .i_supply_is_5v(s5v),
        .i_timing_cap_nf(cap), .i_manual_reset_n(mr_n), .i_watchdog_kick_in(kick), .i_cs_raw_n(cs_raw_n),
        .o_reset_n(rst_n), .o_reset(rst), .o_lowline_n(ll_n), .o_overvoltage_n(ov_n),
        .o_watchdog_fault_n(wdf_n), .o_watchdog_pulse_n(wdp_n), .o_cs_gated_n(cs_n),
        .o_lowline_sense_input_oe_n(oe_n));
    ssw_host_model u_host (
        .i_clk(i_clk), .i_arst_n(i_arst_n), .i_reset_n(rst_n), .i_kick_en(kick_en),
        .i_cs_req(cs_req), .o_kick(kick), .o_cs_raw_n(cs_raw_n));
    task automatic results();
        if (num_errors == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : results
    task automatic tick(input int k);
        repeat (k) begin
            @(posedge i_clk);
            #1;
        end
    endtask : tick
    task automatic cmp_bit(input string name, input logic exp, input logic got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %b seen %b", name, exp, got);
        end
    endtask : cmp_bit
    task automatic cmp_range(input string name, input int got, input int lo, input int hi);
        check_count++;
        if (got < lo || got > hi) begin
            num_errors++;
            $display("CHECK FAILED %s expected %0d..%0d seen %0d", name, lo, hi, got);
        end
    endtask : cmp_range
    function automatic logic pick(input int sel);
        case (sel)
            0: return rst_n;
            1: return wdp_n;
            2: return wdf_n;
            default: return cs_n;
        endcase
    endfunction : pick
    // Bounded wait for an output level, returns cycles taken
    task automatic wait_out(input int sel, input logic v, input int lim, output int cyc);
        cyc = 0;
        while (pick(sel) !== v) begin
            tick(1);
            cyc++;
            if (cyc > lim) begin
                num_errors++;
                $display("CHECK FAILED wait output %0d expected %b seen %b", sel, v, pick(sel));
                results();
            end
        end
    endtask : wait_out
    task automatic asserted(input string name);
        tick(2);
        cmp_bit(name, 1'b0, rst_n);
        cmp_bit("reset inverse", 1'b1, rst);
    endtask : asserted
    task automatic released(input string name);
        wait_out(0, 1'b1, STR + 10, n);
        cmp_range(name, n, STR, STR + 4);
        cmp_bit("reset inverse", 1'b0, rst);
    endtask : released
    initial begin
        repeat (6) @(posedge i_clk);
        #1 i_arst_n = 1'b1;
        cmp_bit("power-on reset", 1'b0, rst_n);
        released("power-on stretch");
        vbr = 1'b1;
        asserted("internal supply reset");
        tick(5);
        vbr = 1'b0;
        released("supply stretch");
        mr_n = 1'b0;
        tick(500);
        cmp_bit("manual reset held", 1'b0, rst_n);
        mr_n = 1'b1;
        released("manual stretch");
        ext = 1'b1;
        vbr = 1'b1;
        tick(3);
        cmp_bit("supply ignored in external mode", 1'b1, rst_n);
        vbr = 1'b0;
        rsl = 1'b1;
        asserted("external sense reset");
        rsl = 1'b0;
        released("external stretch");
        for (int m = 0; m < 2; m++) begin
            ext = m[0];
            lsl = (m == 0);
            vbl = (m != 0);
            tick(2);
            cmp_bit("reference drive enable", m[0], oe_n);
            cmp_bit("low-line wrong source", 1'b1, ll_n);
            vbl = 1'b1;
            lsl = 1'b1;
            tick(2);
            cmp_bit("low-line warning", 1'b0, ll_n);
            vbl = 1'b0;
            lsl = 1'b0;
            tick(2);
            cmp_bit("low-line clear", 1'b1, ll_n);
        end
        ext = 1'b0;
        ovh = 1'b1;
        tick(2);
        cmp_bit("overvoltage flag", 1'b0, ov_n);
        cmp_bit("overvoltage no reset", 1'b1, rst_n);
        ovh = 1'b0;
        tick(2);
        cmp_bit("overvoltage clear", 1'b1, ov_n);
        cs_req = 1'b1;
        tick(2);
        cmp_bit("gated select passes", 1'b0, cs_n);
        vbr = 1'b1;
        wait_out(3, 1'b1, ssw_pkg::CS_HOLD_CYC + 20, n);
        cmp_range("select hold", n, ssw_pkg::CS_HOLD_CYC, ssw_pkg::CS_HOLD_CYC + 5);
        cmp_bit("select blocked in reset", 1'b1, cs_n);
        vbr = 1'b0;
        released("select stretch");
        tick(2);
        cmp_bit("select after release", 1'b0, cs_n);
        vbr = 1'b1;
        tick(10);
        cs_req = 1'b0;
        tick(2);
        cmp_bit("hold ends on raw high", 1'b1, cs_n);
        cs_req = 1'b1;
        tick(3);
        cmp_bit("raw low in reset", 1'b1, cs_n);
        vbr = 1'b0;
        cs_req = 1'b0;
        released("select stretch two");
        kick_en = 1'b1;
        tick(3 * WDT);
        cmp_bit("kicks prevent fault", 1'b1, wdf_n);
        kick_en = 1'b0;
        wait_out(1, 1'b0, WDT + 20, n);
        cmp_range("default timeout", n, WDT - 12, WDT + 3);
        cmp_bit("pulse leads fault", 1'b1, wdf_n);
        tick(1);
        cmp_bit("fault after pulse", 1'b0, wdf_n);
        wait_out(1, 1'b1, WDP + 5, n);
        cmp_range("pulse width", n, WDP - 1, WDP);
        tick(WDT + 10);
        cmp_bit("fault holds", 1'b0, wdf_n);
        cmp_bit("no second pulse", 1'b1, wdp_n);
        kick_en = 1'b1;
        wait_out(2, 1'b1, 15, n);
        kick_en = 1'b0;
        wait_out(1, 1'b0, WDT + 20, n);
        tick(2);
        mr_n = 1'b0;
        tick(3);
        cmp_bit("fault cleared by reset", 1'b1, wdf_n);
        cmp_bit("pulse cleared by reset", 1'b1, wdp_n);
        tick(500);
        mr_n = 1'b1;
        released("watchdog stretch");
        tied = 1'b0;
        cap = 16'h0001;
        for (int v = 0; v < 2; v++) begin
            s5v = v[0];
            lim = CPT * int'(v ? ssw_pkg::WDT_K5V_X10 : ssw_pkg::WDT_K3V_X10);
            kick_en = 1'b1;
            tick(30);
            kick_en = 1'b0;
            wait_out(1, 1'b0, lim + 20, n);
            cmp_range("capacitor timeout", n, lim - 12, lim + 3);
            kick_en = 1'b1;
            wait_out(2, 1'b1, 30, n);
        end
        results();
    end
endmodule : tb_top

// *** core/ssw_counter.sv ***
// Saturating up counter with synchronous clear
`timescale 1ns/1ps
module ssw_counter #(
    parameter int unsigned W = 32
) (
    input  wire logic         i_clk,
    input  wire logic         i_arst_n,
    input  wire logic         i_clr,
    input  wire logic         i_en,
    output logic [W-1:0]      o_count
);
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_count <= '0;
        end else if (i_clr) begin
            o_count <= '0;
        end else if (i_en && (o_count != {W{1'b1}})) begin
            o_count <= o_count + {{(W-1){1'b0}}, 1'b1};
        end
    end
endmodule : ssw_counter

// *** core/ssw_supervisor.sv ***
// Supply supervisor: reset generation, low-line, overvoltage, watchdog, chip-select gate
//
// How it works
// R1: reset_n low while supply below threshold (internal) or reset sense low (external).
// R2: after recovery, reset stays asserted a further 200 ms.
// R3: active-high reset is always the exact inverse of active-low reset.
// R4: mode input low selects internal thresholds, high selects external programming.
// R5: external mode uses low-line sense input; internal mode ignores it.
// R6: overvoltage flag low when overvoltage sense high; affects nothing else.
// R7: timeout select tied high gives default 1.6 s watchdog timeout.
// R8: capacitor on timeout select gives timeout of k times capacitance, k 27 or 16.2.
// R9: power-fail warning low on low supply (internal) or low-line sense low (external).
// R10: kick idle past timeout gives low pulse and drives fault output low.
// R11: fault output stays low until the next kick transition.
// R12: pulse lasts at least 500 us and leads the fault output by ~70 ns; the code leads by one clock cycle (50 ns).
// R13: gated chip-select low only when raw select low and either reset not asserted or the R14 hold window applies.
// R14: select low at reset assertion stays low up to 15 us or raw high.
// R15: outside party ties unused sense inputs to a level, never floating.
// R16: reset held while manual reset low; stretch starts after release.
// R17: during reset, watchdog and pulse counters clear, watchdog outputs high, chip-select gate disabled except for the R14 hold window.
// R18: comparators are synchronous inputs; all durations counted in clock cycles.
// R19: reset asserted at power-on; watchdog restarts on every kick edge.
`timescale 1ns/1ps
module ssw_supervisor #(
    parameter int unsigned STRETCH_CYC = ssw_pkg::STRETCH_CYC,
    parameter int unsigned WDT_DEFAULT_CYC = ssw_pkg::WDT_DEFAULT_CYC,
    parameter int unsigned WDPULSE_CYC = ssw_pkg::WDPULSE_CYC,
    parameter int unsigned CYC_PER_TENTH_MS = ssw_pkg::CYC_PER_TENTH_MS
) (
    input  wire logic        i_clk,
    input  wire logic        i_arst_n,
    input  wire logic        i_ext_mode,            // Mode select comparator, high = external
    input  wire logic        i_vcc_below_reset,     // Internal divider under reset threshold
    input  wire logic        i_vcc_below_lowline,   // Internal divider under low-line threshold
    input  wire logic        i_reset_sense_low,     // Reset sense under 1.30 V
    input  wire logic        i_lowline_sense_input_low, // Low-line sense under 1.30 V
    input  wire logic        i_overvoltage_sense_in_high, // Overvoltage sense above 1.30 V
    input  wire logic        i_timeout_select_input_tied, // Timeout select tied to supply
    input  wire logic        i_supply_is_5v,        // Scale factor select for capacitor timing
    input  wire logic [15:0] i_timing_cap_nf,       // Capacitance on timeout select, nF
    input  wire logic        i_manual_reset_n,
    input  wire logic        i_watchdog_kick_in,
    input  wire logic        i_cs_raw_n,
    output logic             o_reset_n,
    output logic             o_reset,
    output logic             o_lowline_n,
    output logic             o_overvoltage_n,
    output logic             o_watchdog_fault_n,
    output logic             o_watchdog_pulse_n,
    output logic             o_cs_gated_n,
    output logic             o_lowline_sense_input_oe_n // Low while the reference drives the pin
);
    localparam int unsigned CW = ssw_pkg::CNT_W;

    ssw_pkg::ssw_rst_state_t rst_state_q;
    logic          rst_cause;
    logic          rst_active;
    logic [CW-1:0] stretch_cnt;
    logic [CW-1:0] wdt_cnt;
    logic [CW-1:0] pulse_cnt;
    logic [CW-1:0] cs_cnt;
    logic [CW-1:0] wdt_limit;
    logic          kick_q;
    logic          kick_edge;
    logic          wdt_expired;
    logic          pulse_active_q;
    logic          lead_q;
    logic          fault_n_q;
    logic          rst_active_q;
    logic          cs_hold_q;

    // Reset causes per mode
    always_comb begin
        rst_cause = (i_ext_mode ? i_reset_sense_low : i_vcc_below_reset) // see R1, see R4
                    || !i_manual_reset_n;                                   // see R16
    end

    // Reset sequencer, held at power-on
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_state_q <= ssw_pkg::SSW_RST_HOLD;                           // see R19
        end else begin
            case (rst_state_q)
                ssw_pkg::SSW_RST_HOLD: begin
                    if (!rst_cause) begin
                        rst_state_q <= ssw_pkg::SSW_RST_STRETCH;            // see R16
                    end
                end
                ssw_pkg::SSW_RST_STRETCH: begin
                    if (rst_cause) begin
                        rst_state_q <= ssw_pkg::SSW_RST_HOLD;
                    end else if (stretch_cnt >= CW'(STRETCH_CYC - 1)) begin
                        rst_state_q <= ssw_pkg::SSW_RST_RUN;                // see R2
                    end
                end
                ssw_pkg::SSW_RST_RUN: begin
                    if (rst_cause) begin
                        rst_state_q <= ssw_pkg::SSW_RST_HOLD;               // see R1
                    end
                end
                default: begin
                    rst_state_q <= ssw_pkg::SSW_RST_HOLD;
                end
            endcase
        end
    end

    assign rst_active = (rst_state_q != ssw_pkg::SSW_RST_RUN);

    ssw_counter #(.W(CW)) u_stretch_cnt (                                   // see R18
        .i_clk    (i_clk),
        .i_arst_n (i_arst_n),
        .i_clr    (rst_state_q != ssw_pkg::SSW_RST_STRETCH),
        .i_en     (1'b1),
        .o_count  (stretch_cnt)
    );

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_reset_n <= 1'b0;
            o_reset   <= 1'b1;
        end else begin
            o_reset_n <= !rst_active;
            o_reset   <= rst_active;                                        // see R3
        end
    end

    // Low-line warning and overvoltage flag
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_lowline_n     <= 1'b1;
            o_overvoltage_n <= 1'b1;
        end else begin
            o_lowline_n     <= !(i_ext_mode ? i_lowline_sense_input_low   // see R5, see R9
                                            : i_vcc_below_lowline);
            o_overvoltage_n <= !i_overvoltage_sense_in_high;                // see R6
        end
    end

    // Pin carries the reference in internal mode
    assign o_lowline_sense_input_oe_n = i_ext_mode;                         // see R5

    // Watchdog timeout select
    always_comb begin
        if (i_timeout_select_input_tied) begin
            wdt_limit = CW'(WDT_DEFAULT_CYC);                               // see R7
        end else begin
            wdt_limit = CW'(32'(i_timing_cap_nf) * (i_supply_is_5v ? ssw_pkg::WDT_K5V_X10
                        : ssw_pkg::WDT_K3V_X10) * CYC_PER_TENTH_MS); // see R8
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            kick_q <= 1'b0;
        end else begin
            kick_q <= i_watchdog_kick_in;
        end
    end

    assign kick_edge = kick_q != i_watchdog_kick_in;

    ssw_counter #(.W(CW)) u_wdt_cnt (
        .i_clk    (i_clk),
        .i_arst_n (i_arst_n),
        .i_clr    (rst_active || kick_edge),                                // see R17, see R19
        .i_en     (1'b1),
        .o_count  (wdt_cnt)
    );

    assign wdt_expired = !rst_active && !kick_edge && fault_n_q && !pulse_active_q
                         && (wdt_cnt >= wdt_limit);                         // see R10

    // Advance pulse, then fault output one lead later
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pulse_active_q <= 1'b0;
        end else if (rst_active) begin
            pulse_active_q <= 1'b0;                                         // see R17
        end else if (wdt_expired) begin
            pulse_active_q <= 1'b1;                                         // see R10
        end else if (pulse_cnt >= CW'(WDPULSE_CYC - 1)) begin
            pulse_active_q <= 1'b0;                                         // see R12
        end
    end

    ssw_counter #(.W(CW)) u_pulse_cnt (
        .i_clk    (i_clk),
        .i_arst_n (i_arst_n),
        .i_clr    (!pulse_active_q),
        .i_en     (1'b1),
        .o_count  (pulse_cnt)
    );

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            lead_q <= 1'b0;
        end else begin
            lead_q <= wdt_expired && !rst_active;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            fault_n_q <= 1'b1;
        end else if (rst_active) begin
            fault_n_q <= 1'b1;                                              // see R17
        end else if (lead_q) begin
            fault_n_q <= 1'b0;                                              // see R12
        end else if (kick_edge) begin
            fault_n_q <= 1'b1;                                              // see R11
        end
    end

    assign o_watchdog_fault_n = fault_n_q;
    assign o_watchdog_pulse_n = !pulse_active_q;

    // Chip-select gate with hold window at reset assertion
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_active_q <= 1'b1;
        end else begin
            rst_active_q <= rst_active;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cs_hold_q <= 1'b0;
        end else if (i_cs_raw_n || !rst_active) begin
            cs_hold_q <= 1'b0;
        end else if (rst_active && !rst_active_q && !o_cs_gated_n) begin
            cs_hold_q <= 1'b1;                                              // see R14
        end else if (cs_cnt >= CW'(ssw_pkg::CS_HOLD_CYC - 1)) begin
            cs_hold_q <= 1'b0;
        end
    end

    ssw_counter #(.W(CW)) u_cs_cnt (
        .i_clk    (i_clk),
        .i_arst_n (i_arst_n),
        .i_clr    (!cs_hold_q),
        .i_en     (1'b1),
        .o_count  (cs_cnt)
    );

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_cs_gated_n <= 1'b1;
        end else begin
            o_cs_gated_n <= !(!i_cs_raw_n && (!rst_active                   // see R13
                             || (rst_active && !rst_active_q && !o_cs_gated_n) || cs_hold_q)); // see R14
        end
    end

    // Checks
    chk_reset_inverse: assert property (@(posedge i_clk) disable iff (!i_arst_n) // see R3
        o_reset == !o_reset_n) else $error("reset outputs not inverse");
    chk_reset_cause: assert property (@(posedge i_clk) disable iff (!i_arst_n) // see R1
        rst_cause |-> ##2 !o_reset_n) else $error("reset not asserted on cause");
    chk_mr_hold: assert property (@(posedge i_clk) disable iff (!i_arst_n) // see R16
        !i_manual_reset_n |=> rst_state_q == ssw_pkg::SSW_RST_HOLD) else $error("manual reset not held");
    chk_stretch_len: assert property (@(posedge i_clk) disable iff (!i_arst_n) // see R2
        (rst_state_q == ssw_pkg::SSW_RST_RUN && $past(rst_state_q) == ssw_pkg::SSW_RST_STRETCH)
        |-> $past(stretch_cnt) == CW'(STRETCH_CYC - 1)) else $error("stretch length wrong");
    chk_ov_flag: assert property (@(posedge i_clk) disable iff (!i_arst_n) // see R6
        i_overvoltage_sense_in_high |=> !o_overvoltage_n) else $error("overvoltage flag missing");
    chk_pulse_lead: assert property (@(posedge i_clk) disable iff (!i_arst_n) // see R12
        $fell(fault_n_q) |-> !o_watchdog_pulse_n && $past(!o_watchdog_pulse_n)) else $error("pulse not leading");
    chk_fault_release: assert property (@(posedge i_clk) disable iff (!i_arst_n) // see R11
        (!fault_n_q && kick_edge) |=> fault_n_q) else $error("fault not released on kick");
    chk_wdog_in_reset: assert property (@(posedge i_clk) disable iff (!i_arst_n) // see R17
        rst_active |=> o_watchdog_pulse_n && o_watchdog_fault_n) else $error("watchdog active in reset");
    chk_cs_gate: assert property (@(posedge i_clk) disable iff (!i_arst_n) // see R13
        (i_cs_raw_n) |=> o_cs_gated_n) else $error("chip select low with raw high");
endmodule : ssw_supervisor

// *** include/ssw_pkg.sv ***
// Constants for the supply supervisor and watchdog block
package ssw_pkg;
    localparam int unsigned CLK_HZ          = 20000000;
    localparam int unsigned CLK_PERIOD_NS   = 50;
    // Reset stretch after recovery
    localparam int unsigned STRETCH_MS      = 200;
    localparam int unsigned STRETCH_CYC     = STRETCH_MS * (CLK_HZ / 1000);
    // Default watchdog timeout
    localparam int unsigned WDT_DEFAULT_MS  = 1600;
    localparam int unsigned WDT_DEFAULT_CYC = WDT_DEFAULT_MS * (CLK_HZ / 1000);
    // Timeout scale per nF of timing capacitor, in tenths of a millisecond
    localparam int unsigned WDT_K5V_X10     = 270;
    localparam int unsigned WDT_K3V_X10     = 162;
    localparam int unsigned CYC_PER_TENTH_MS = CLK_HZ / 10000;
    // Watchdog pulse, least width
    localparam int unsigned WDPULSE_US      = 500;
    localparam int unsigned WDPULSE_CYC     = (WDPULSE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Lead of pulse over fault output
    localparam int unsigned PULSE_LEAD_NS   = 70;
    localparam int unsigned PULSE_LEAD_CYC  = (PULSE_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Chip-select hold after reset assertion, longest
    localparam int unsigned CS_HOLD_US      = 15;
    localparam int unsigned CS_HOLD_CYC     = (CS_HOLD_US * 1000) / CLK_PERIOD_NS;
    localparam int unsigned CNT_W           = 32;
    localparam logic [15:0] CAP_NF_RESET    = 16'h0000;

    typedef enum logic [1:0] {
        SSW_RST_HOLD    = 2'b00,
        SSW_RST_STRETCH = 2'b01,
        SSW_RST_RUN     = 2'b11
    } ssw_rst_state_t;
endpackage : ssw_pkg
